// ===== rtl/gss_selector.sv
// Servo gain set selector: picks the original, first or second gain set each
// control cycle and ramps eight gain outputs toward it with a first-order lag.
// Assumes all inputs are synchronous to ref_clk and steady within a control cycle.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
module gss_selector
#(
   parameter int CTRL_CYCLES = gss_pkg::CTRL_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [gss_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [gss_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [gss_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [15:0] control_input_word_one,
   input wire logic [15:0] control_input_word_five,
   input wire logic gain_switch_input,
   input wire logic gain_switch2_input,
   input wire logic [2:0] control_mode,
   input wire logic motor_stopped,
   input wire logic cmd_dir_neg,
   input wire logic cmd_dir_pos,
   input wire logic [gss_pkg::LVL_W-1:0] cmd_freq,
   input wire logic [gss_pkg::LVL_W-1:0] droop_pulses,
   input wire logic [gss_pkg::LVL_W-1:0] motor_speed,
   input wire logic slight_vib_active,
   output logic [gss_pkg::N_GAINS-1:0][gss_pkg::GAIN_W-1:0] gain_out,
   output logic [1:0] active_set,
   output logic ramp_busy
);
   localparam int TICK_W = $clog2(CTRL_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CTRL_CYCLES - 1);

   typedef struct packed {
      logic [3:0] adj_mode;
      logic [1:0] variant;
      logic [3:0] sel;
      logic [3:0] sense;
      logic [3:0] tcdis;
      logic [3:0] sel2;
      logic [3:0] stop_en;
      logic [gss_pkg::LVL_W-1:0] lvl1;
      logic [gss_pkg::TC_W-1:0] tc1;
      logic [gss_pkg::LVL_W-1:0] lvl2;
      logic [gss_pkg::TC_W-1:0] tc2;
      logic [TICK_W-1:0] tick;
      logic [1:0] tgt;
      logic [1:0] src;
      logic [gss_pkg::TC_W-1:0] tc_now;
      logic instant;
      logic busy;
      logic [3:0] step;
      logic hold;
      logic [gss_pkg::N_GAINS-1:0][gss_pkg::GAIN_W-1:0] gains;
      logic [gss_pkg::DATA_W-1:0] rdata;
   } gss_sel_s;

   gss_sel_s state_reg;
   gss_sel_s state_next;
   gss_mem_if mem_bus ();

   gss_gain_mem u_mem
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .port(mem_bus.mem)
   );

   // Level comparison in the direction chosen by the sense field.
   function automatic logic level_hit(input logic [gss_pkg::LVL_W-1:0] value,
                                      input logic [gss_pkg::LVL_W-1:0] level,
                                      input logic [3:0] sense);
      if (sense == gss_pkg::SENSE_ABOVE)
      begin
         return value >= level;
      end
      return value <= level;
   endfunction

   // One first-order lag step; never stalls short of the target.
   function automatic logic [gss_pkg::GAIN_W-1:0] lag_step(
      input logic [gss_pkg::GAIN_W-1:0] cur,
      input logic [gss_pkg::GAIN_W-1:0] tgt,
      input logic [gss_pkg::TC_W-1:0] tc,
      input logic instant);
      logic signed [gss_pkg::GAIN_W+1:0] diff;
      logic signed [gss_pkg::GAIN_W+1:0] div;
      logic signed [gss_pkg::GAIN_W+1:0] q;
      diff = $signed({2'b00, tgt}) - $signed({2'b00, cur});
      div = $signed({2'b00, tc}) + 18'sh00001;
      if (instant || (tc == '0))
      begin
         return tgt;
      end
      q = diff / div;
      if ((q == '0) && (diff != '0))
      begin
         q = diff[gss_pkg::GAIN_W+1] ? -18'sh00001 : 18'sh00001;
      end
      return gss_pkg::GAIN_W'($signed({2'b00, cur}) + q);
   endfunction

   logic sig1;
   logic sig2;
   logic dir_ok;
   logic dir_hit;
   logic [gss_pkg::LVL_W-1:0] lvl_val;
   logic cond1;
   logic cond2;
   logic [1:0] pick;
   logic [2:0] g_rd;
   logic [2:0] g_up;
   logic [1:0] eff_set;
   logic in_gains;
   logic [gss_pkg::ADDR_W-1:0] gain_off;

   always_comb
   begin
      // Switch signals per variant: network takes input or command bit.
      unique case (gss_pkg::gss_variant_e'(state_reg.variant))
         gss_pkg::GSS_VAR_NET:
         begin
            sig1 = gain_switch_input | control_input_word_one[gss_pkg::CMD_BIT];
            sig2 = gain_switch2_input | control_input_word_five[gss_pkg::CMD_BIT];
         end
         gss_pkg::GSS_VAR_CTRL:
         begin
            sig1 = control_input_word_one[gss_pkg::CMD_BIT];
            sig2 = control_input_word_five[gss_pkg::CMD_BIT];
         end
         default:
         begin
            sig1 = gain_switch_input;
            sig2 = gain_switch2_input;
         end
      endcase
      dir_ok = (gss_pkg::gss_mode_e'(control_mode) != gss_pkg::GSS_MODE_CONT_TORQUE);
      if (motor_stopped)
      begin
         dir_ok = dir_ok && (state_reg.stop_en == gss_pkg::STOP_EN)
                  && ((gss_pkg::gss_mode_e'(control_mode) == gss_pkg::GSS_MODE_POS)
                  || ((state_reg.variant == gss_pkg::GSS_VAR_NET)
                  && (gss_pkg::gss_mode_e'(control_mode) == gss_pkg::GSS_MODE_POSITIONING)));
      end
      dir_hit = (state_reg.sense == gss_pkg::SENSE_ABOVE) ? cmd_dir_neg : cmd_dir_pos;
      unique case (state_reg.sel)
         gss_pkg::GSS_SRC_FREQ: lvl_val = cmd_freq;
         gss_pkg::GSS_SRC_DROOP: lvl_val = droop_pulses;
         default: lvl_val = motor_speed;
      endcase
      cond1 = 1'b0;
      cond2 = 1'b0;
      unique case (state_reg.sel)
         gss_pkg::GSS_SRC_SIGNAL:
            cond1 = (state_reg.sense == gss_pkg::SENSE_ABOVE) ? sig1 : !sig1;
         gss_pkg::GSS_SRC_FREQ, gss_pkg::GSS_SRC_DROOP, gss_pkg::GSS_SRC_SPEED:
            cond1 = level_hit(lvl_val, state_reg.lvl1, state_reg.sense);
         gss_pkg::GSS_SRC_DIR:
            cond1 = dir_hit && dir_ok;
         default:
            cond1 = 1'b0;
      endcase
      unique case (state_reg.sel2)
         gss_pkg::GSS_SRC2_SIGNAL:
            cond2 = sig2;
         gss_pkg::GSS_SRC2_SAME:
         begin
            if (state_reg.sel == gss_pkg::GSS_SRC_SIGNAL)
            begin
               cond2 = sig2;
            end
            else if (state_reg.sel == gss_pkg::GSS_SRC_DIR)
            begin
               cond2 = dir_hit && dir_ok;
            end
            else if (state_reg.sel != gss_pkg::GSS_SRC_OFF)
            begin
               cond2 = (state_reg.lvl2 != '0)
                       && level_hit(lvl_val, state_reg.lvl2, state_reg.sense);
            end
         end
         default:
            cond2 = 1'b0;
      endcase
      pick = gss_pkg::SET_ORIG;
      if (state_reg.adj_mode == gss_pkg::MODE_MANUAL)
      begin
         pick = cond2 ? gss_pkg::SET_TWO : (cond1 ? gss_pkg::SET_ONE : gss_pkg::SET_ORIG);
      end
   end

   always_comb
   begin
      state_next = state_reg;
      g_rd = state_reg.step[2:0];
      g_up = 3'(state_reg.step - 4'h1);
      // Model and vibration gains of a switched set need that set's signal.
      eff_set = state_reg.tgt;
      if ((g_rd == gss_pkg::G_MODEL) || (g_rd >= gss_pkg::G_VIB_FIRST))
      begin
         if ((state_reg.tgt == gss_pkg::SET_ONE) && !sig1)
         begin
            eff_set = gss_pkg::SET_ORIG;
         end
         if ((state_reg.tgt == gss_pkg::SET_TWO) && !sig2)
         begin
            eff_set = gss_pkg::SET_ORIG;
         end
      end
      mem_bus.raddr = {eff_set, g_rd};
      in_gains = (reg_addr >= gss_pkg::A_GAIN_FIRST) && (reg_addr <= gss_pkg::A_GAIN_LAST)
                 && (reg_addr[1:0] == 2'b00);
      gain_off = reg_addr - gss_pkg::A_GAIN_FIRST;
      mem_bus.we = reg_wr && in_gains;
      mem_bus.waddr = gain_off[gss_pkg::MEM_AW+1:2];
      mem_bus.wdata = reg_wdata[gss_pkg::GAIN_W-1:0];

      if (reg_wr)
      begin
         unique case (reg_addr)
            gss_pkg::A_CTRL:
            begin
               state_next.adj_mode = reg_wdata[gss_pkg::CTRL_MODE_LSB +: 4];
               state_next.variant = reg_wdata[gss_pkg::CTRL_VARIANT_LSB +: 2];
            end
            gss_pkg::A_FUNC:
            begin
               state_next.sel = reg_wdata[gss_pkg::FUNC_SEL_LSB +: 4];
               state_next.sense = reg_wdata[gss_pkg::FUNC_SENSE_LSB +: 4];
               state_next.tcdis = reg_wdata[gss_pkg::FUNC_TCDIS_LSB +: 4];
               state_next.sel2 = reg_wdata[gss_pkg::FUNC_SEL2_LSB +: 4];
               state_next.stop_en = reg_wdata[gss_pkg::FUNC_STOP_LSB +: 4];
            end
            gss_pkg::A_LEVEL: state_next.lvl1 = reg_wdata[gss_pkg::LVL_W-1:0];
            gss_pkg::A_TIME: state_next.tc1 = reg_wdata[gss_pkg::TC_W-1:0];
            gss_pkg::A_LEVEL2: state_next.lvl2 = reg_wdata[gss_pkg::LVL_W-1:0];
            gss_pkg::A_TIME2: state_next.tc2 = reg_wdata[gss_pkg::TC_W-1:0];
            default: ;
         endcase
      end

      state_next.rdata = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            gss_pkg::A_CTRL:
            begin
               state_next.rdata[gss_pkg::CTRL_MODE_LSB +: 4] = state_reg.adj_mode;
               state_next.rdata[gss_pkg::CTRL_VARIANT_LSB +: 2] = state_reg.variant;
            end
            gss_pkg::A_FUNC:
            begin
               state_next.rdata[gss_pkg::FUNC_SEL_LSB +: 4] = state_reg.sel;
               state_next.rdata[gss_pkg::FUNC_SENSE_LSB +: 4] = state_reg.sense;
               state_next.rdata[gss_pkg::FUNC_TCDIS_LSB +: 4] = state_reg.tcdis;
               state_next.rdata[gss_pkg::FUNC_SEL2_LSB +: 4] = state_reg.sel2;
               state_next.rdata[gss_pkg::FUNC_STOP_LSB +: 4] = state_reg.stop_en;
            end
            gss_pkg::A_LEVEL: state_next.rdata[gss_pkg::LVL_W-1:0] = state_reg.lvl1;
            gss_pkg::A_TIME: state_next.rdata[gss_pkg::TC_W-1:0] = state_reg.tc1;
            gss_pkg::A_LEVEL2: state_next.rdata[gss_pkg::LVL_W-1:0] = state_reg.lvl2;
            gss_pkg::A_TIME2: state_next.rdata[gss_pkg::TC_W-1:0] = state_reg.tc2;
            gss_pkg::A_STATUS:
            begin
               state_next.rdata[gss_pkg::STAT_SET_LSB +: 2] = state_reg.tgt;
               state_next.rdata[gss_pkg::STAT_SRC_LSB +: 2] = state_reg.src;
               state_next.rdata[gss_pkg::STAT_BUSY_BIT] = state_reg.busy;
            end
            default: ;
         endcase
      end

      // Control cycle timer; the set is chosen and registered on its wrap.
      if (state_reg.tick == TICK_LAST)
      begin
         state_next.tick = '0;
         state_next.tgt = pick;
         state_next.busy = 1'b1;
         state_next.step = '0;
         if (pick != state_reg.tgt)
         begin
            state_next.src = state_reg.tgt;
            if (pick == gss_pkg::SET_TWO)
            begin
               state_next.tc_now = state_reg.tc2;
            end
            else if (pick == gss_pkg::SET_ONE)
            begin
               state_next.tc_now = state_reg.tc1;
            end
            else
            begin
               state_next.tc_now = (state_reg.tgt == gss_pkg::SET_TWO) ? state_reg.tc2
                                                                       : state_reg.tc1;
            end
            state_next.instant = ((pick != gss_pkg::SET_ORIG)
                                  && (state_reg.tcdis == gss_pkg::TCDIS_AT_SWITCH))
                                 || ((pick == gss_pkg::SET_ORIG)
                                  && (state_reg.tcdis == gss_pkg::TCDIS_AT_RETURN));
         end
      end
      else
      begin
         state_next.tick = state_reg.tick + TICK_W'(1);
      end

      // Walk: read gain k while updating gain k-1 from the memory's registered output.
      if (state_reg.busy && (state_reg.tick != TICK_LAST))
      begin
         state_next.hold = slight_vib_active && (g_rd <= gss_pkg::G_LAST_HELD);
         if ((state_reg.step != '0) && !state_reg.hold)
         begin
            state_next.gains[g_up] = lag_step(state_reg.gains[g_up], mem_bus.rdata,
                                              state_reg.tc_now, state_reg.instant);
         end
         if (state_reg.step == gss_pkg::WALK_END)
         begin
            state_next.busy = 1'b0;
         end
         else
         begin
            state_next.step = state_reg.step + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata = state_reg.rdata;
   assign gain_out = state_reg.gains;
   assign active_set = state_reg.tgt;
   assign ramp_busy = state_reg.busy;
endmodule

// ===== shared/gss_pkg.sv
// Constants, field layouts and enumerations of the servo gain set selector.
// Assumes one 50 MHz control clock and a plain register port with byte addresses.
// Behaviour
// - Switching only in manual adjust mode 3.
// - Network: set-one vibration gains need switch one.
// - Network: set-two vibration gains need switch two.
// - Controller variant: vibration gains need controller command.
// - Network: direction-at-stop in position, positioning modes.
// - Other variants: direction-at-stop only position mode.
// - No direction switching in continuous torque mode.
// - Slight vibration control freezes first five gains.
// - Both conditions true: second set wins.
// - Second level zero never selects second set by level; signal or direction still can.
// - First level compares frequency, droop or speed.
// - Ramp into first set uses first time.
// - Ramp into second set uses second time.
// - Switch on signal, frequency, droop, speed or direction.
// - Source codes: off, signal, freq, droop, speed, direction.
// - Sense zero: at or above; one: at or below.
// - Second source: off, signal, same as first.
package gss_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CTRL_PERIOD_NS = 1000000;
   localparam int CTRL_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   localparam int GAIN_W = 16;
   localparam int N_GAINS = 8;
   localparam int N_SETS = 3;
   localparam int MEM_AW = 5;
   localparam int LVL_W = 16;
   localparam int TC_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FUNC = 8'h04;
   localparam logic [7:0] A_LEVEL = 8'h08;
   localparam logic [7:0] A_TIME = 8'h0C;
   localparam logic [7:0] A_LEVEL2 = 8'h10;
   localparam logic [7:0] A_TIME2 = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   localparam logic [7:0] A_GAIN_FIRST = 8'h40;
   localparam logic [7:0] A_GAIN_LAST = 8'h9C;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_VARIANT_LSB = 4;
   localparam int FUNC_SEL_LSB = 0;
   localparam int FUNC_SENSE_LSB = 4;
   localparam int FUNC_TCDIS_LSB = 8;
   localparam int FUNC_SEL2_LSB = 16;
   localparam int FUNC_STOP_LSB = 20;
   localparam int STAT_SET_LSB = 0;
   localparam int STAT_SRC_LSB = 4;
   localparam int STAT_BUSY_BIT = 8;
   localparam int CMD_BIT = 4;

   localparam logic [3:0] MODE_MANUAL = 4'h3;
   localparam logic [3:0] SENSE_ABOVE = 4'h0;
   localparam logic [3:0] TCDIS_AT_SWITCH = 4'h1;
   localparam logic [3:0] TCDIS_AT_RETURN = 4'h2;
   localparam logic [3:0] STOP_EN = 4'h1;
   localparam logic [1:0] SET_ORIG = 2'h0;
   localparam logic [1:0] SET_ONE = 2'h1;
   localparam logic [1:0] SET_TWO = 2'h2;
   localparam logic [2:0] G_MODEL = 3'h1;
   localparam logic [2:0] G_LAST_HELD = 3'h4;
   localparam logic [2:0] G_VIB_FIRST = 3'h5;
   localparam logic [3:0] WALK_END = 4'h8;

   typedef enum logic [3:0] {
      GSS_SRC_OFF = 4'h0,
      GSS_SRC_SIGNAL = 4'h1,
      GSS_SRC_FREQ = 4'h2,
      GSS_SRC_DROOP = 4'h3,
      GSS_SRC_SPEED = 4'h4,
      GSS_SRC_DIR = 4'h5
   } gss_src_e;

   typedef enum logic [3:0] {
      GSS_SRC2_OFF = 4'h0,
      GSS_SRC2_SIGNAL = 4'h1,
      GSS_SRC2_SAME = 4'h2
   } gss_src2_e;

   typedef enum logic [1:0] {
      GSS_VAR_NET = 2'h0,
      GSS_VAR_CTRL = 2'h1,
      GSS_VAR_PULSE = 2'h2
   } gss_variant_e;

   typedef enum logic [2:0] {
      GSS_MODE_POS = 3'h0,
      GSS_MODE_POSITIONING = 3'h1,
      GSS_MODE_SPEED = 3'h2,
      GSS_MODE_TORQUE = 3'h3,
      GSS_MODE_CONT_TORQUE = 3'h4
   } gss_mode_e;
endpackage

// ===== shared/gss_mem_if.sv
// Port between the selector and its gain table memory.
// Assumes both ends run on the same control clock.
`timescale 1ns/10ps
interface gss_mem_if;
   logic we;
   logic [gss_pkg::MEM_AW-1:0] waddr;
   logic [gss_pkg::GAIN_W-1:0] wdata;
   logic [gss_pkg::MEM_AW-1:0] raddr;
   logic [gss_pkg::GAIN_W-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ===== rtl/gss_gain_mem.sv
// Gain table: three sets of eight gains, one write port and one registered read.
// Assumes a synchronous active-low reset that clears every word.
`timescale 1ns/10ps
module gss_gain_mem
(
   input wire logic ref_clk,
   input wire logic rstn,
   gss_mem_if.mem port
);
   localparam int DEPTH = gss_pkg::N_SETS * gss_pkg::N_GAINS;

   typedef struct packed {
      logic [DEPTH-1:0][gss_pkg::GAIN_W-1:0] words;
      logic [gss_pkg::GAIN_W-1:0] rdata;
   } gss_mem_s;

   gss_mem_s state_reg;
   gss_mem_s state_next;

   always_comb
   begin
      state_next = state_reg;
      if (port.we && (int'(port.waddr) < DEPTH))
      begin
         state_next.words[port.waddr] = port.wdata;
      end
      state_next.rdata = '0;
      if (int'(port.raddr) < DEPTH)
      begin
         state_next.rdata = state_reg.words[port.raddr];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign port.rdata = state_reg.rdata;
endmodule

// ===== verification/gss_cmd_model.sv
// Model of the motion controller and switch input devices that feed the selector.
// Assumes requests come from the bench; outputs change only after a clock edge.
`timescale 1ns/10ps
module gss_cmd_model
(
   input wire logic ref_clk,
   input wire logic sw1_req,
   input wire logic sw2_req,
   input wire logic cmd1_req,
   input wire logic cmd2_req,
   output logic [15:0] control_input_word_one = 16'h0000,
   output logic [15:0] control_input_word_five = 16'h0000,
   output logic gain_switch_input = 1'b0,
   output logic gain_switch2_input = 1'b0
);
   logic [15:0] noise = 16'h5A5A;
   // Unrelated word bits keep moving so that only bit 4 may steer the selector.
   always @(posedge ref_clk)
   begin
      noise <= noise + 16'h1357;
      control_input_word_one <= {noise[15:5], cmd1_req, noise[3:0]};
      control_input_word_five <= {~noise[15:5], cmd2_req, ~noise[3:0]};
      gain_switch_input <= sw1_req;
      gain_switch2_input <= sw2_req;
   end
endmodule

// ===== verification/gss_selector_sva.sv
// Port checker of the gain set selector, bound into every gss_selector.
// Assumes the synchronous active-low reset rstn and one clock ref_clk.
`timescale 1ns/10ps
module gss_selector_chk
#(
   parameter int CTRL_CYCLES = 20
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [gss_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [gss_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [gss_pkg::DATA_W-1:0] reg_rdata,
   input wire logic slight_vib_active,
   input wire logic [gss_pkg::N_GAINS-1:0][gss_pkg::GAIN_W-1:0] gain_out,
   input wire logic [1:0] active_set,
   input wire logic ramp_busy
);
   logic [3:0] mode_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // Mirrors the adjust mode field so that manual mode can be judged at a tick.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         mode_q <= 4'h0;
      else if (reg_wr && reg_addr == gss_pkg::A_CTRL)
         mode_q <= reg_wdata[3:0];
   end
   rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside read");
   unmapped_rd_a: assert property (reg_rd && reg_addr >= 8'h1C |=> reg_rdata == '0)
      else $error("unmapped or gain read not zero");
   status_echo_a: assert property (reg_rd && reg_addr == gss_pkg::A_STATUS |=>
      reg_rdata[1:0] == $past(active_set) && reg_rdata[31:9] == '0)
      else $error("status read does not show active set");
   set_range_a: assert property (active_set != 2'h3)
      else $error("illegal set index");
   set_on_tick_a: assert property ($changed(active_set) |-> $rose(ramp_busy))
      else $error("set changed outside a tick");
   walk_len_a: assert property ($rose(ramp_busy) |->
      ramp_busy[*8] ##1 ramp_busy ##1 !ramp_busy)
      else $error("gain walk length wrong");
   tick_period_a: assert property ($rose(ramp_busy) |-> ##CTRL_CYCLES $rose(ramp_busy))
      else $error("control tick period wrong");
   gain_hold_a: assert property (!ramp_busy && !$past(ramp_busy) |-> $stable(gain_out))
      else $error("gains moved outside walk");
   not_manual_a: assert property ($rose(ramp_busy) && $past(mode_q) != gss_pkg::MODE_MANUAL |->
      active_set == gss_pkg::SET_ORIG)
      else $error("switched set outside manual mode");
   vib_hold_a: assert property (slight_vib_active[*8] |-> $stable(gain_out[4:0]))
      else $error("held gains moved under slight vibration");
   cover property ($rose(ramp_busy) && active_set == gss_pkg::SET_ONE);
   cover property ($rose(ramp_busy) && active_set == gss_pkg::SET_TWO);
   cover property (reg_rd ##1 reg_rdata != '0);
endmodule
bind gss_selector gss_selector_chk #(.CTRL_CYCLES(CTRL_CYCLES)) chk_u (.ref_clk, .rstn,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slight_vib_active, .gain_out,
   .active_set, .ramp_busy);

// ===== verification/gss_selector_tb.sv
// Self-checking bench of gss_selector with a short control cycle of 20 clocks.
// Assumes gss_cmd_model drives the controller words and switch inputs.
`timescale 1ns/10ps
module gss_selector_tb;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [15:0] control_input_word_one, control_input_word_five;
   logic gain_switch_input, gain_switch2_input;
   logic s1 = 1'b0, s2 = 1'b0, c1 = 1'b0, c2 = 1'b0;
   logic [2:0] control_mode = 3'h0;
   logic motor_stopped = 1'b0, cmd_dir_neg = 1'b0, cmd_dir_pos = 1'b0;
   logic slight_vib_active = 1'b0;
   logic [15:0] cmd_freq = 16'h0, droop_pulses = 16'h0, motor_speed = 16'h0, v;
   logic [7:0][15:0] gain_out, cur = '0;
   logic [1:0] active_set;
   logic ramp_busy, pbusy = 1'b0, prd = 1'b0;
   logic [129:0] exp_q[$];
   logic [31:0] rd_q[$];
   int fails = 0, samples_checked = 0, seed = 74154;
   always #10 ref_clk = ~ref_clk;
   gss_cmd_model pm_u (.ref_clk, .sw1_req(s1), .sw2_req(s2), .cmd1_req(c1), .cmd2_req(c2),
      .control_input_word_one, .control_input_word_five, .gain_switch_input,
      .gain_switch2_input);
   gss_selector #(.CTRL_CYCLES(20)) dut_u (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .control_input_word_one, .control_input_word_five,
      .gain_switch_input, .gain_switch2_input, .control_mode, .motor_stopped, .cmd_dir_neg,
      .cmd_dir_pos, .cmd_freq, .droop_pulses, .motor_speed, .slight_vib_active, .gain_out,
      .active_set, .ramp_busy);
   task automatic stop_test;
      $display("mismatches=%0d checks=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [129:0] got, input logic [129:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Results are compared half a cycle after they appear, clear of the driver.
   always @(negedge ref_clk)
   begin
      pbusy <= ramp_busy;
      prd <= reg_rd;
      if (prd && rd_q.size() > 0)
         chk(130'(reg_rdata), 130'(rd_q.pop_front()));
      if (pbusy && !ramp_busy && exp_q.size() > 0)
         chk({active_set, gain_out}, exp_q.pop_front());
   end
   function automatic logic [31:0] fn(input logic [3:0] sel, input logic [3:0] sense,
      input logic [3:0] sel2, input logic [3:0] stop);
      return {8'h00, stop, sel2, 8'h00, sense, sel};
   endfunction
   function automatic logic [15:0] tv(input logic [1:0] s, input int g);
      return {2'h0, s + 2'h1, 12'(g)};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic settle;
      int n;
      for (n = 0; n < 60 && !ramp_busy; n++) @(posedge ref_clk) #1;
      for (n = n; n < 60 && ramp_busy; n++) @(posedge ref_clk) #1;
      if (n >= 60)
      begin
         fails++;
         stop_test();
      end
      @(posedge ref_clk);
   endtask
   // Notes the outcome of the next control cycle, then waits for its walk.
   task automatic walk(input logic [1:0] es, input logic sig, input int tc);
      int d, q;
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
         d = int'(tv((((i == 1) || (i > 4)) && !sig) ? 2'h0 : es, i)) - int'(cur[i]);
         q = d / (tc + 1);
         if (q == 0 && d != 0)
            q = (d > 0) ? 1 : -1;
         if (!(slight_vib_active && i < 5))
            cur[i] = 16'(int'(cur[i]) + q);
      end
      exp_q.push_back({es, cur});
      settle();
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      s1 <= 1'b1;
      wr(gss_pkg::A_FUNC, fn(4'h1, 4'h0, 4'h1, 4'h0));
      for (int s = 0; s < 3; s++)
         for (int g = 0; g < 8; g++)
            wr(8'(32'(gss_pkg::A_GAIN_FIRST) + 4 * (8 * s + g)), 32'(tv(2'(s), g)));
      settle();
      walk(2'h0, 1'b1, 0);
      wr(gss_pkg::A_CTRL, 32'h3);
      walk(2'h1, 1'b1, 0);
      rd(gss_pkg::A_STATUS, 32'h1);
      s1 <= 1'b0;
      c1 <= 1'b1;
      walk(2'h1, 1'b1, 0);
      s2 <= 1'b1;
      walk(2'h2, 1'b1, 0);
      s2 <= 1'b0;
      c2 <= 1'b1;
      walk(2'h2, 1'b1, 0);
      c1 <= 1'b0;
      c2 <= 1'b0;
      wr(gss_pkg::A_FUNC, fn(4'h2, 4'h0, 4'h2, 4'h0));
      wr(gss_pkg::A_LEVEL, 32'd100);
      wr(gss_pkg::A_LEVEL2, 32'd200);
      cmd_freq <= 16'd150;
      walk(2'h1, 1'b0, 0);
      cmd_freq <= 16'd250;
      walk(2'h2, 1'b0, 0);
      wr(gss_pkg::A_LEVEL2, 32'd0);
      walk(2'h1, 1'b0, 0);
      for (int src = 2; src < 5; src++)
      begin
         v = 16'(101 + ({$random(seed)} % 900));
         wr(gss_pkg::A_FUNC, fn(4'(src), 4'h0, 4'h0, 4'h0));
         cmd_freq <= (src == 2) ? v : 16'h0;
         droop_pulses <= (src == 3) ? v : 16'h0;
         motor_speed <= (src == 4) ? v : 16'h0;
         walk(2'h1, 1'b0, 0);
      end
      wr(gss_pkg::A_FUNC, fn(4'h4, 4'h1, 4'h0, 4'h0));
      motor_speed <= 16'd50;
      walk(2'h1, 1'b0, 0);
      wr(gss_pkg::A_FUNC, fn(4'h5, 4'h0, 4'h0, 4'h1));
      cmd_dir_neg <= 1'b1;
      walk(2'h1, 1'b0, 0);
      control_mode <= 3'h4;
      walk(2'h0, 1'b0, 0);
      control_mode <= 3'h0;
      motor_stopped <= 1'b1;
      walk(2'h1, 1'b0, 0);
      control_mode <= 3'h2;
      walk(2'h0, 1'b0, 0);
      control_mode <= 3'h1;
      walk(2'h1, 1'b0, 0);
      wr(gss_pkg::A_CTRL, 32'h13);
      walk(2'h0, 1'b0, 0);
      control_mode <= 3'h0;
      walk(2'h1, 1'b0, 0);
      motor_stopped <= 1'b0;
      cmd_dir_neg <= 1'b0;
      wr(gss_pkg::A_FUNC, fn(4'h2, 4'h0, 4'h0, 4'h0));
      cmd_freq <= 16'd150;
      s1 <= 1'b1;
      walk(2'h1, 1'b0, 0);
      c1 <= 1'b1;
      walk(2'h1, 1'b1, 0);
      wr(gss_pkg::A_FUNC, fn(4'h2, 4'h0, 4'h2, 4'h0));
      wr(gss_pkg::A_LEVEL2, 32'd200);
      cmd_freq <= 16'd250;
      c2 <= 1'b1;
      slight_vib_active <= 1'b1;
      walk(2'h2, 1'b1, 0);
      slight_vib_active <= 1'b0;
      cmd_freq <= 16'd0;
      walk(2'h0, 1'b1, 0);
      wr(gss_pkg::A_TIME, 32'd1);
      wr(gss_pkg::A_TIME2, 32'd3);
      cmd_freq <= 16'd150;
      walk(2'h1, 1'b1, 1);
      cmd_freq <= 16'd250;
      walk(2'h2, 1'b1, 3);
      wr(gss_pkg::A_CTRL, 32'h23);
      wr(gss_pkg::A_FUNC, 32'h20102);
      cmd_freq <= 16'd150;
      c1 <= 1'b0;
      walk(2'h1, 1'b1, 0);
      wr(8'hE0, $random(seed));
      rd(8'hE0, 32'h0);
      rd(gss_pkg::A_GAIN_FIRST, 32'h0);
      rd(gss_pkg::A_CTRL, 32'h23);
      rd(gss_pkg::A_TIME2, 32'h3);
      stop_test();
   end
endmodule
